// >>> rtl/rmc_pkg.sv
// package: register map, reset values, modes, states and timing of the modem tx/rx control
package rmc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int RMC_CLK_HZ = 125_000_000;
	localparam int RMC_MS_CYCLES = RMC_CLK_HZ / 1000;
	localparam int RMC_SETTLE_MS = 64;
	localparam int RMC_BAUD_RST = 19200;
	localparam int RMC_CHAR_BITS = 10;
	localparam int RMC_CHAR_CYCLES = RMC_CLK_HZ / (RMC_BAUD_RST / RMC_CHAR_BITS);
	localparam int RMC_TXB_DEPTH = 1024;
	localparam int RMC_RPT_DEPTH = 1024;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] RMC_A_CTRL = 8'h00;
	localparam logic [7:0] RMC_A_TXDLY = 8'h04;
	localparam logic [7:0] RMC_A_PAUSE = 8'h08;
	localparam logic [7:0] RMC_A_CHARDIV = 8'h0c;
	localparam logic [7:0] RMC_A_SYNCINT = 8'h10;
	localparam logic [7:0] RMC_A_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RMC_CTRL_MODE_LSB = 0;
	localparam int RMC_CTRL_DUAL_BIT = 3;
	localparam int RMC_ST_STATE_LSB = 0;
	localparam int RMC_ST_RXACT_BIT = 8;
	localparam int RMC_ST_RPTRDY_BIT = 9;
	localparam int RMC_ST_DIAG_BIT = 10;
	localparam int RMC_ST_LEVEL_LSB = 16;

	// ----------------------------------------------------------------
	// protocol modes and controller states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RMC_M_RXPRI = 3'h0,
		RMC_M_TXPRI = 3'h1,
		RMC_M_RPT = 3'h2,
		RMC_M_ADVM = 3'h3,
		RMC_M_ADVS = 3'h4
	} rmc_mode_t;

	typedef enum logic [4:0] {
		RMC_S_IDLE = 5'h01,
		RMC_S_DELAY = 5'h02,
		RMC_S_TUNE_TX = 5'h04,
		RMC_S_SEND = 5'h08,
		RMC_S_TUNE_RX = 5'h10
	} rmc_state_t;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam rmc_mode_t RMC_MODE_RST = RMC_M_TXPRI;
	localparam logic RMC_DUAL_RST = 1'b0;
	localparam logic [15:0] RMC_TXDLY_RST = 16'h0000;
	localparam logic [7:0] RMC_PAUSE_RST = 8'h03;
	localparam logic [23:0] RMC_CHARDIV_RST = 24'(RMC_CHAR_CYCLES);
	localparam logic [15:0] RMC_SYNCINT_RST = 16'h0000;

endpackage

// >>> rtl/rmc_txrx_ctrl.sv
// top: half-duplex radio modem transmit/receive control with an ahb-lite register slave
//
// Behaviour
// - with split channels, rest on the receive channel when idle
// - terminal data keys the transmitter and tunes to the transmit channel
// - with split channels, wait 64 ms after tuning to transmit, and 64 ms tuning back
// - optional delay of 1 to 65535 ms before every transmission of terminal data; store-and-forward starts without it
// - terminal data arriving during the delay is buffered
// - transmit delay resets to zero
// - end transmission when buffer empty and serial gap seen (default 3 chars)
// - end transmission when the transmit buffer overflows
// - sync and message header sent at start of a transmission and at start of each new frame
// - lost reception drops the message and hunts for a new start
// - at the frame-size limit close frame, resend sync, start new frame
// - exactly one of five protocol modes is active
// - advanced and basic modes discard each other's messages
// - advanced modes repeat a received message when it asks for it
// - receive-priority: transmit buffered data only after reception ends
// - receive-priority: local config command aborts reception at once
// - transmit-priority: terminal data aborts reception and keys transmitter
// - mode resets to basic transmit-priority
// - diagnostics off in basic receive- and transmit-priority modes
// - repeater stores up to 1 kB and forwards only good messages
// - repeater: terminal data held until forwarding is done
// - store-and-forward finishes before any other transmission
`timescale 1ns/1ps
module rmc_txrx_ctrl
	import rmc_pkg::*;
#(
	parameter int MS_CYCLES = rmc_pkg::RMC_MS_CYCLES,
	parameter int TXB_DEPTH = rmc_pkg::RMC_TXB_DEPTH,
	parameter int RPT_DEPTH = rmc_pkg::RMC_RPT_DEPTH
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// terminal equipment side
	input wire logic term_in_valid,
	input wire logic [7:0] term_in_data,
	input wire logic term_in_cmd,
	output logic term_out_valid,
	output logic [7:0] term_out_data,
	output logic cfg_cmd_pulse,
	// radio receiver
	input wire logic rf_rx_start,
	input wire logic rf_rx_adv,
	input wire logic rf_rx_fwd,
	input wire logic rf_rx_valid,
	input wire logic [7:0] rf_rx_data,
	input wire logic rf_rx_end,
	input wire logic rf_rx_ok,
	input wire logic rf_rx_lost,
	output logic rf_rx_abort,
	// radio transmitter
	input wire logic rf_tx_ready,
	output logic tx_key,
	output logic chan_tx,
	output logic rf_tx_sync,
	output logic rf_tx_valid,
	output logic [7:0] rf_tx_data,
	output logic rf_tx_eof,
	output logic diag_en
);
	import rmc_pkg::*;

	localparam int TAW = $clog2(TXB_DEPTH);
	localparam int RAW = $clog2(RPT_DEPTH);

	function automatic logic mode_ok(input logic [2:0] m);
		mode_ok = (m <= RMC_M_ADVS);
	endfunction

	function automatic logic is_adv(input rmc_mode_t m);
		is_adv = (m == RMC_M_ADVM) || (m == RMC_M_ADVS);
	endfunction

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	rmc_mode_t mode_r;
	logic dual_r;
	logic [15:0] txdly_r;
	logic [7:0] pause_r;
	logic [23:0] chardiv_r;
	logic [15:0] syncint_r;
	logic ap_wr_r;
	logic [7:0] ap_addr_r;
	logic [31:0] rd_mux;
	rmc_state_t st_r;
	logic [TAW:0] tx_cnt_r;
	logic rx_act_r;
	logic rpt_rdy_r;

	wire logic ap_take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r <= 1'b0;
			ap_addr_r <= 8'h00;
		end else begin
			ap_wr_r <= ap_take && hwrite;
			if (ap_take) begin
				ap_addr_r <= haddr[7:0];
			end
		end
	end

	// writes land at the end of the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= RMC_MODE_RST;
			dual_r <= RMC_DUAL_RST;
			txdly_r <= RMC_TXDLY_RST;
			pause_r <= RMC_PAUSE_RST;
			chardiv_r <= RMC_CHARDIV_RST;
			syncint_r <= RMC_SYNCINT_RST;
		end else if (ap_wr_r) begin
			case (ap_addr_r)
				RMC_A_CTRL: begin
					// only a defined mode code is taken
					if (mode_ok(hwdata[RMC_CTRL_MODE_LSB +: 3])) begin
						mode_r <= rmc_mode_t'(hwdata[RMC_CTRL_MODE_LSB +: 3]);
					end
					dual_r <= hwdata[RMC_CTRL_DUAL_BIT];
				end
				RMC_A_TXDLY: txdly_r <= hwdata[15:0];
				RMC_A_PAUSE: pause_r <= hwdata[7:0];
				RMC_A_CHARDIV: chardiv_r <= hwdata[23:0];
				RMC_A_SYNCINT: syncint_r <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			RMC_A_CTRL: begin
				rd_mux[RMC_CTRL_MODE_LSB +: 3] = mode_r;
				rd_mux[RMC_CTRL_DUAL_BIT] = dual_r;
			end
			RMC_A_TXDLY: rd_mux[15:0] = txdly_r;
			RMC_A_PAUSE: rd_mux[7:0] = pause_r;
			RMC_A_CHARDIV: rd_mux[23:0] = chardiv_r;
			RMC_A_SYNCINT: rd_mux[15:0] = syncint_r;
			RMC_A_STATUS: begin
				rd_mux[RMC_ST_STATE_LSB +: 5] = st_r;
				rd_mux[RMC_ST_RXACT_BIT] = rx_act_r;
				rd_mux[RMC_ST_RPTRDY_BIT] = rpt_rdy_r;
				rd_mux[RMC_ST_DIAG_BIT] = diag_en;
				rd_mux[RMC_ST_LEVEL_LSB +: TAW + 1] = tx_cnt_r;
			end
			default: ;
		endcase
	end

	// zero wait states, so read data is captured with the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= (ap_take && !hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// serial gap detector
	// ----------------------------------------------------------------
	logic [23:0] gap_cyc_r;
	logic [7:0] gap_chr_r;
	wire logic term_data = term_in_valid && !term_in_cmd;
	wire logic gap_met = (gap_chr_r >= pause_r);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_cyc_r <= 24'h000000;
			gap_chr_r <= 8'h00;
		end else if (term_data) begin
			gap_cyc_r <= 24'h000000;
			gap_chr_r <= 8'h00;
		end else if (gap_cyc_r + 24'h000001 >= chardiv_r) begin
			gap_cyc_r <= 24'h000000;
			if (gap_chr_r != 8'hff) begin
				gap_chr_r <= gap_chr_r + 8'h01;
			end
		end else begin
			gap_cyc_r <= gap_cyc_r + 24'h000001;
		end
	end

	// ----------------------------------------------------------------
	// transmit buffer
	// ----------------------------------------------------------------
	logic [7:0] tx_mem [TXB_DEPTH];
	logic [TAW-1:0] tx_wp_r;
	logic [TAW-1:0] tx_rp_r;
	logic src_rpt_r;
	logic need_sync_r;
	logic ovf_r;
	logic [15:0] frame_cnt_r;
	logic [7:0] rpt_mem [RPT_DEPTH];
	logic [RAW:0] rpt_wp_r;
	logic [RAW:0] rpt_rp_r;
	logic [RAW:0] rpt_len_r;

	wire logic tx_full = (tx_cnt_r == (TAW + 1)'(TXB_DEPTH));
	wire logic tx_push = term_data && !tx_full;
	wire logic src_empty = src_rpt_r ? (rpt_rp_r == rpt_len_r) : (tx_cnt_r == '0);
	wire logic frame_full = (syncint_r != 16'h0000) && (frame_cnt_r == syncint_r);
	wire logic send_done = src_rpt_r ? src_empty : ((src_empty && gap_met) || ovf_r);
	wire logic in_send = (st_r == RMC_S_SEND);
	wire logic send_byte = in_send && !need_sync_r && !send_done && !frame_full
		&& !src_empty && rf_tx_ready;
	wire logic tx_pop = send_byte && !src_rpt_r;

	// data held while the delay runs
	always_ff @(posedge hclk) begin
		if (tx_push) begin
			tx_mem[tx_wp_r] <= term_in_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_cnt_r <= '0;
		end else begin
			if (tx_push) begin
				tx_wp_r <= tx_wp_r + 1'b1;
			end
			if (tx_pop) begin
				tx_rp_r <= tx_rp_r + 1'b1;
			end
			tx_cnt_r <= tx_cnt_r + (TAW + 1)'(tx_push) - (TAW + 1)'(tx_pop);
		end
	end

	// ----------------------------------------------------------------
	// controller timer, restarted on each state change
	// ----------------------------------------------------------------
	logic [31:0] tmr_cyc_r;
	logic [16:0] tmr_ms_r;
	rmc_state_t st_nxt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmr_cyc_r <= 32'h0000_0000;
			tmr_ms_r <= 17'h00000;
		end else if (st_nxt != st_r) begin
			tmr_cyc_r <= 32'h0000_0000;
			tmr_ms_r <= 17'h00000;
		end else if (tmr_cyc_r == 32'(MS_CYCLES - 1)) begin
			tmr_cyc_r <= 32'h0000_0000;
			tmr_ms_r <= tmr_ms_r + 17'h00001;
		end else begin
			tmr_cyc_r <= tmr_cyc_r + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// transmit state machine
	// ----------------------------------------------------------------
	logic rpt_busy;
	logic term_go;
	logic start_tx;
	logic start_rpt;
	logic settled;

	assign rpt_busy = rpt_rdy_r || (rx_act_r && (mode_r == RMC_M_RPT || is_adv(mode_r)));
	// receive-priority waits for reception to end
	assign term_go = (tx_cnt_r != '0) && !rpt_busy
		&& !(mode_r == RMC_M_RXPRI && rx_act_r);
	assign start_rpt = rpt_rdy_r && !rx_act_r;
	// 64 ms settling only when channels differ
	assign settled = !dual_r || (tmr_ms_r >= 17'(RMC_SETTLE_MS));

	always_comb begin
		st_nxt = st_r;
		start_tx = 1'b0;
		case (st_r)
			RMC_S_IDLE: begin
				if (start_rpt) begin
					start_tx = 1'b1;
				end else if (term_go) begin
					if (txdly_r != 16'h0000) begin
						st_nxt = RMC_S_DELAY;
					end else begin
						start_tx = 1'b1;
					end
				end
			end
			RMC_S_DELAY: begin
				if (start_rpt) begin
					start_tx = 1'b1;
				end else if (tmr_ms_r >= {1'b0, txdly_r} && term_go) begin
					start_tx = 1'b1;
				end
			end
			RMC_S_TUNE_TX: begin
				if (settled) begin
					st_nxt = RMC_S_SEND;
				end
			end
			RMC_S_SEND: begin
				if (!need_sync_r && send_done) begin
					st_nxt = RMC_S_TUNE_RX;
				end
			end
			RMC_S_TUNE_RX: begin
				if (settled) begin
					st_nxt = RMC_S_IDLE;
				end
			end
			default: st_nxt = RMC_S_IDLE;
		endcase
		if (start_tx) begin
			st_nxt = RMC_S_TUNE_TX;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= RMC_S_IDLE;
			src_rpt_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (start_tx) begin
				src_rpt_r <= start_rpt;
			end
		end
	end

	// keying and channel follow the state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_key <= 1'b0;
			chan_tx <= 1'b0;
		end else begin
			tx_key <= (st_nxt == RMC_S_TUNE_TX) || (st_nxt == RMC_S_SEND);
			chan_tx <= dual_r && ((st_nxt == RMC_S_TUNE_TX) || (st_nxt == RMC_S_SEND));
		end
	end

	// framing inside a transmission
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			need_sync_r <= 1'b0;
			frame_cnt_r <= 16'h0000;
			ovf_r <= 1'b0;
			rf_tx_sync <= 1'b0;
			rf_tx_eof <= 1'b0;
			rf_tx_valid <= 1'b0;
			rf_tx_data <= 8'h00;
		end else begin
			rf_tx_sync <= 1'b0;
			rf_tx_eof <= 1'b0;
			rf_tx_valid <= send_byte;
			// overflow while sending; the excess byte is dropped
			if (in_send && !src_rpt_r && term_data && tx_full) begin
				ovf_r <= 1'b1;
			end
			if (st_r == RMC_S_TUNE_TX) begin
				need_sync_r <= 1'b1;
				ovf_r <= 1'b0;
			end else if (in_send) begin
				if (need_sync_r) begin
					// header only at the start of a frame
					rf_tx_sync <= 1'b1;
					need_sync_r <= 1'b0;
					frame_cnt_r <= 16'h0000;
				end else if (send_done) begin
					rf_tx_eof <= 1'b1;
					ovf_r <= 1'b0;
				end else if (frame_full) begin
					rf_tx_eof <= 1'b1;
					need_sync_r <= 1'b1;
				end else if (send_byte) begin
					frame_cnt_r <= frame_cnt_r + 16'h0001;
					rf_tx_data <= src_rpt_r ? rpt_mem[rpt_rp_r[RAW-1:0]] : tx_mem[tx_rp_r];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// receive path and store-and-forward
	// ----------------------------------------------------------------
	logic rx_keep_r;
	logic rx_bad_r;
	logic rx_abort;
	logic rx_accept;

	// only messages of the own mode family
	assign rx_accept = rf_rx_start && !rx_act_r && (rf_rx_adv == is_adv(mode_r))
		&& (st_r == RMC_S_IDLE || st_r == RMC_S_DELAY);
	assign rx_abort = rx_act_r && ((mode_r == RMC_M_RXPRI && term_in_valid && term_in_cmd)
		|| (mode_r == RMC_M_TXPRI && term_data) || start_tx);

	always_ff @(posedge hclk) begin
		if (rx_act_r && rx_keep_r && rf_rx_valid && !rpt_wp_r[RAW]) begin
			rpt_mem[rpt_wp_r[RAW-1:0]] <= rf_rx_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_act_r <= 1'b0;
			rx_keep_r <= 1'b0;
			rx_bad_r <= 1'b0;
			rpt_wp_r <= '0;
		end else if (rx_abort || (rx_act_r && rf_rx_lost)) begin
			// drop and hunt for the next start
			rx_act_r <= 1'b0;
			rx_keep_r <= 1'b0;
		end else if (rx_accept) begin
			rx_act_r <= 1'b1;
			// repeat in repeater mode or on request in advanced modes
			rx_keep_r <= !rpt_rdy_r && ((mode_r == RMC_M_RPT) || (is_adv(mode_r) && rf_rx_fwd));
			rx_bad_r <= 1'b0;
			rpt_wp_r <= '0;
		end else if (rx_act_r && rf_rx_end) begin
			rx_act_r <= 1'b0;
			rx_keep_r <= 1'b0;
		end else if (rx_act_r && rx_keep_r && rf_rx_valid) begin
			// longer than the store means not forwarded
			if (rpt_wp_r[RAW]) begin
				rx_bad_r <= 1'b1;
			end else begin
				rpt_wp_r <= rpt_wp_r + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rpt_rdy_r <= 1'b0;
			rpt_len_r <= '0;
			rpt_rp_r <= '0;
		end else begin
			// only a correctly received message is forwarded
			if (rx_act_r && rx_keep_r && rf_rx_end && !rf_rx_lost && !rx_abort
				&& rf_rx_ok && !rx_bad_r) begin
				rpt_rdy_r <= 1'b1;
				rpt_len_r <= rpt_wp_r;
			end else if (in_send && src_rpt_r && !need_sync_r && send_done) begin
				rpt_rdy_r <= 1'b0;
			end
			if (start_tx) begin
				rpt_rp_r <= '0;
			end else if (send_byte && src_rpt_r) begin
				rpt_rp_r <= rpt_rp_r + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// terminal outputs and diagnostics
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			term_out_valid <= 1'b0;
			term_out_data <= 8'h00;
			cfg_cmd_pulse <= 1'b0;
			rf_rx_abort <= 1'b0;
			diag_en <= 1'b0;
		end else begin
			term_out_valid <= rx_act_r && rf_rx_valid && !rx_abort && !rf_rx_lost;
			if (rx_act_r && rf_rx_valid) begin
				term_out_data <= rf_rx_data;
			end
			cfg_cmd_pulse <= term_in_valid && term_in_cmd;
			rf_rx_abort <= rx_abort;
			// diagnostics only outside basic priority modes
			diag_en <= (mode_r != RMC_M_RXPRI) && (mode_r != RMC_M_TXPRI);
		end
	end

endmodule // rmc_txrx_ctrl

// >>> testbench/radio_modem_txrx_control_test.sv
// testbench: register, transmit and receive scenarios for the modem control
`timescale 1ns/1ps
module radio_modem_txrx_control_test;
	import rmc_pkg::*;
	localparam int LIMIT = 20000;
	localparam logic [5:0] P_ST = 6'h20, P_ADV = 6'h10, P_VAL = 6'h08, P_END = 6'h04;
	localparam logic [5:0] P_OK = 6'h02, P_LOST = 6'h01;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rf_rx_fwd, rf_tx_ready;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0] rxc;
	logic [7:0] rf_rx_data, term_out_data, rf_tx_data;
	logic term_out_valid, cfg_cmd_pulse, rf_rx_abort, tx_key, chan_tx;
	logic rf_tx_sync, rf_tx_valid, rf_tx_eof, diag_en;
	wire hready, term_in_valid, term_in_cmd;
	wire [7:0] term_in_data;
	wire rf_rx_start, rf_rx_adv, rf_rx_valid, rf_rx_end, rf_rx_ok, rf_rx_lost;
	int bad_count, cmp_count, cyc, t0, sync_n, eof_n, out_n, ab_n;
	logic [7:0] txq[$], outq[$];

	assign hready = hreadyout;
	assign {rf_rx_start, rf_rx_adv, rf_rx_valid, rf_rx_end, rf_rx_ok, rf_rx_lost} = rxc;

	// short millisecond and small buffers keep the run brief
	rmc_txrx_ctrl #(.MS_CYCLES(10), .TXB_DEPTH(16), .RPT_DEPTH(16)) uut (.*);
	rmc_term_model u_term (.*);

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rfp(input logic [5:0] s, input logic [7:0] d);
		@(posedge hclk);
		rxc <= s;
		rf_rx_data <= d;
		@(posedge hclk);
		rxc <= 6'h0;
		rf_rx_data <= ~d;
	endtask

	task automatic till_eof(input int k);
		while (eof_n < k) @(posedge hclk);
	endtask

	// ------------------------------------------------------------
	// monitors and timeout
	// ------------------------------------------------------------
	always @(posedge hclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			bad_count++;
			stop_test();
		end
		if (rf_tx_sync === 1'b1) sync_n++;
		if (rf_tx_eof === 1'b1) eof_n++;
		if (rf_rx_abort === 1'b1) ab_n++;
		if (rf_tx_valid === 1'b1) txq.push_back(rf_tx_data);
		if (term_out_valid === 1'b1) begin
			out_n++;
			outq.push_back(term_out_data);
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		rxc = 6'h0;
		rf_rx_data = 8'h00;
		rf_rx_fwd = 1'b0;
		rf_tx_ready = 1'b1;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, RMC_A_CTRL, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b0, RMC_A_TXDLY, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, RMC_A_PAUSE, 32'h0);
		chk(rd, 32'h3);
		ahb(1'b0, RMC_A_STATUS, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		for (int m = 0; m < 5; m++) begin
			ahb(1'b1, RMC_A_CTRL, 32'(m));
			repeat (2) @(posedge hclk);
			chk(diag_en, 32'(m >= 2));
		end
		// mode code 5 is refused and the old mode stays
		ahb(1'b1, RMC_A_CTRL, 32'h5);
		ahb(1'b0, RMC_A_CTRL, 32'h0);
		chk(rd, 32'h4);
		chk(hresp, 32'h0);
		// single byte, one channel; short character time keeps the gap brief
		ahb(1'b1, RMC_A_CHARDIV, 32'h4);
		ahb(1'b1, RMC_A_CTRL, 32'h1);
		u_term.send(1, 8'ha5, 1'b0);
		t0 = cyc;
		till_eof(1);
		chk(32'(cyc - t0 >= 10), 32'h1);
		chk(sync_n, 32'h1);
		chk(txq.pop_front(), 8'ha5);
		// transmit delay of 2 ms, bytes held meanwhile
		ahb(1'b1, RMC_A_TXDLY, 32'h2);
		u_term.send(2, 8'h10, 1'b0);
		t0 = cyc;
		ahb(1'b0, RMC_A_STATUS, 32'h0);
		chk(rd & 32'h07ff001f, 32'h00020002);
		while (tx_key !== 1'b1) @(posedge hclk);
		chk(32'(cyc - t0 >= 18), 32'h1);
		till_eof(2);
		chk(txq.pop_front(), 8'h10);
		chk(txq.pop_front(), 8'h11);
		ahb(1'b1, RMC_A_TXDLY, 32'h0);
		// split channels: 64 ms each way
		ahb(1'b1, RMC_A_CTRL, 32'h9);
		u_term.send(1, 8'h77, 1'b0);
		while (chan_tx !== 1'b1) @(posedge hclk);
		t0 = cyc;
		while (sync_n < 3) @(posedge hclk);
		chk(32'(cyc - t0 >= 640), 32'h1);
		till_eof(3);
		@(posedge hclk);
		chk(chan_tx, 32'h0);
		ahb(1'b0, RMC_A_STATUS, 32'h0);
		chk(rd[4:0], 5'h10);
		repeat (640) @(posedge hclk);
		ahb(1'b0, RMC_A_STATUS, 32'h0);
		chk(rd[4:0], 5'h01);
		chk(txq.pop_front(), 8'h77);
		// modulator stalls until the buffer overflows
		ahb(1'b1, RMC_A_CTRL, 32'h1);
		rf_tx_ready <= 1'b0;
		u_term.send(1, 8'h20, 1'b0);
		while (sync_n < 4) @(posedge hclk);
		u_term.send(16, 8'h21, 1'b0);
		till_eof(4);
		rf_tx_ready <= 1'b1;
		till_eof(5);
		chk(txq.size(), 32'd16);
		txq.delete();
		// frame limit of two bytes
		ahb(1'b1, RMC_A_SYNCINT, 32'h2);
		u_term.send(3, 8'h40, 1'b0);
		till_eof(7);
		chk(sync_n, 32'd7);
		ahb(1'b1, RMC_A_SYNCINT, 32'h0);
		// transmit priority: terminal data aborts reception
		rfp(P_ST, 8'h00);
		rfp(P_VAL, 8'h3c);
		// one spare edge so the monitor has queued the byte
		repeat (2) @(posedge hclk);
		chk(outq.pop_front(), 8'h3c);
		u_term.send(1, 8'h44, 1'b0);
		repeat (2) @(posedge hclk);
		chk(ab_n, 32'h1);
		till_eof(8);
		txq.delete();
		// receive priority: data waits, command aborts
		ahb(1'b1, RMC_A_CTRL, 32'h0);
		rfp(P_ST, 8'h00);
		u_term.send(1, 8'h55, 1'b0);
		repeat (30) @(posedge hclk);
		chk(sync_n, 32'd8);
		rfp(P_END | P_OK, 8'h00);
		till_eof(9);
		chk(txq.pop_front(), 8'h55);
		rfp(P_ST, 8'h00);
		u_term.send(1, 8'h33, 1'b1);
		repeat (20) @(posedge hclk);
		chk(ab_n, 32'h2);
		chk(sync_n, 32'd9);
		// advanced master: basic traffic ignored, lost message dropped
		ahb(1'b1, RMC_A_CTRL, 32'h3);
		rfp(P_ST, 8'h00);
		rfp(P_VAL, 8'h61);
		rfp(P_ST | P_ADV, 8'h00);
		rfp(P_VAL, 8'h62);
		rfp(P_LOST, 8'h00);
		rfp(P_VAL, 8'h63);
		repeat (2) @(posedge hclk);
		chk(outq.pop_front(), 8'h62);
		chk(outq.size(), 32'h0);
		// advanced master repeats a message that asks for it
		rf_rx_fwd <= 1'b1;
		rfp(P_ST | P_ADV, 8'h00);
		rf_rx_fwd <= 1'b0;
		rfp(P_VAL, 8'h65);
		rfp(P_END | P_OK, 8'h00);
		till_eof(10);
		chk(txq.pop_front(), 8'h65);
		// repeater: stored message goes before held terminal data
		ahb(1'b1, RMC_A_CTRL, 32'h2);
		rfp(P_ST, 8'h00);
		rfp(P_VAL, 8'h71);
		rfp(P_VAL, 8'h72);
		u_term.send(1, 8'h79, 1'b0);
		rfp(P_END | P_OK, 8'h00);
		till_eof(11);
		chk(txq.pop_front(), 8'h71);
		chk(txq.pop_front(), 8'h72);
		till_eof(12);
		chk(txq.pop_front(), 8'h79);
		rfp(P_ST, 8'h00);
		rfp(P_VAL, 8'h81);
		rfp(P_END, 8'h00);
		repeat (30) @(posedge hclk);
		chk(sync_n, 32'd12);
		stop_test();
	end
endmodule // radio_modem_txrx_control_test

// >>> testbench/rmc_term_model.sv
// terminal equipment model: feeds characters to the modem, no back-pressure
`timescale 1ns/1ps
module rmc_term_model (
	// clock
	input wire logic hclk,
	// character stream toward the modem
	output logic term_in_valid,
	output logic [7:0] term_in_data,
	output logic term_in_cmd
);
	logic [7:0] chr_r;
	logic [7:0] noise_r = 8'h5a;

	initial begin
		term_in_valid = 1'b0;
		term_in_cmd = 1'b0;
		chr_r = 8'h00;
	end

	// between characters the data line keeps changing so a stale byte is never reused
	always @(posedge hclk) noise_r <= noise_r + 8'h3b;
	assign term_in_data = term_in_valid ? chr_r : noise_r;

	// n characters back to back, counting up from first
	task automatic send(input int n, input logic [7:0] first, input logic cmd);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			term_in_valid <= 1'b1;
			chr_r <= first + 8'(i);
			term_in_cmd <= cmd;
		end
		@(posedge hclk);
		term_in_valid <= 1'b0;
		term_in_cmd <= 1'b0;
	endtask
endmodule // rmc_term_model

// >>> testbench/rmc_txrx_chk.sv
// checker: port-level assertions for the modem transmit/receive control
`timescale 1ns/1ps
module rmc_txrx_chk #(
	parameter int MS_CYCLES = 125000
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// terminal side
	input wire logic term_in_valid,
	input wire logic term_in_cmd,
	input wire logic term_out_valid,
	input wire logic [7:0] term_out_data,
	input wire logic cfg_cmd_pulse,
	// radio side
	input wire logic rf_rx_start,
	input wire logic rf_rx_valid,
	input wire logic [7:0] rf_rx_data,
	input wire logic rf_rx_lost,
	input wire logic rf_tx_ready,
	input wire logic tx_key,
	input wire logic chan_tx,
	input wire logic rf_tx_sync,
	input wire logic rf_tx_valid,
	input wire logic rf_tx_eof
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ------------------------------------------------------------
	// settle counter
	// ------------------------------------------------------------
	// counts cycles on the tx channel; a 64 ms figure is too long for a repetition
	logic [31:0] tune_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tune_r <= '0;
		else if (!chan_tx)
			tune_r <= '0;
		else
			tune_r <= tune_r + 32'h1;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_rest_rxchan: assert property (chan_tx |-> tx_key)
		else $error("tx channel selected while unkeyed");
	a_settle_wait: assert property (rf_tx_sync && chan_tx
		|-> tune_r >= 32'(64 * MS_CYCLES))
		else $error("sync sent before the channel settled");
	a_sync_keyed: assert property (rf_tx_sync |-> tx_key ##1 !rf_tx_sync)
		else $error("sync outside a keyed transmission or too long");
	a_byte_ready: assert property (rf_tx_valid |-> $past(rf_tx_ready) && tx_key)
		else $error("payload byte without modulator ready");
	a_cmd_pulse: assert property (term_in_valid && term_in_cmd |=> cfg_cmd_pulse)
		else $error("command character not signalled");
	a_lost_drop: assert property (rf_rx_lost ##1 !rf_rx_start |=> !term_out_valid)
		else $error("data delivered after reception was lost");
	a_rx_deliver: assert property (term_out_valid |-> $past(rf_rx_valid)
		&& term_out_data == $past(rf_rx_data))
		else $error("terminal output not from a received byte");
	a_eof_single: assert property (rf_tx_eof |=> !rf_tx_eof)
		else $error("frame close longer than one cycle");

	c_dual_send: cover property (rf_tx_sync && chan_tx);
	c_frame_split: cover property (rf_tx_eof ##1 rf_tx_sync);
	c_rx_byte: cover property (term_out_valid);
endmodule // rmc_txrx_chk

bind rmc_txrx_ctrl rmc_txrx_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
